// ===== rps_defs.vh
// Purpose: shared constants of the reset and position selector block
// Assumes: 50 MHz system clock; times held in milliseconds
// Notes:   cycle counts are derived from these in the top module
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH

// clock rate in kHz, so that ms * kHz gives cycles
`define RPS_CLK_KHZ     50000
// key and input timing, ms
`define RPS_DEB_MS      20
`define RPS_LAMP_MS     10000
`define RPS_FREPL_MS    15000
`define RPS_EXTOFF_MS   2000
`define RPS_TOUT_MS     5000
`define RPS_HALF_MS     500

// selector letters, ascii codes shown on the left segment position
`define RPS_CH_A        8'h41
`define RPS_CH_B        8'h62
`define RPS_CH_C        8'h43
`define RPS_CH_D        8'h64
`define RPS_CH_E        8'h45
`define RPS_CH_F        8'h46
`define RPS_CH_I        8'h49
`define RPS_CH_O        8'h6F
`define RPS_CH_T        8'h54
`define RPS_CH_U        8'h55
`define RPS_CH_V        8'h56
`define RPS_CH_W        8'h57
`define RPS_CH_X        8'h58
`define RPS_CH_R        8'h72
`define RPS_CH_S        8'h53
`define RPS_CH_BLANK    8'h20

// group list: 13 letters, index of the last one and of special letters
`define RPS_GRP_LAST    4'hC
`define RPS_GRP_D       4'h3
`define RPS_GRP_E       4'h4
`define RPS_GRP_F       4'h5
`define RPS_GRP_O       4'h7
`define RPS_GRP_V       4'hA

// position numbers
`define RPS_NUM_MAX     7'h63
`define RPS_SLOT_FIRST  7'h01
// filter options: on, service-life time, replacement, off
`define RPS_FOPT_ON     2'h0
`define RPS_FOPT_TIME   2'h1
`define RPS_FOPT_REPL   2'h2
`define RPS_FOPT_OFF    2'h3
// firmware display lasts this many flash phases; the version shows in every other one
`define RPS_FW_PHASES   3'h6

`endif

// ===== rps_keyin.v
// Purpose: synchronise, debounce and time one key or input pin
// Assumes: pin is asynchronous to clk_in
// Notes:   held_out freezes at release so the caller can judge its length
`timescale 1ns/1ns
`default_nettype none
module rps_keyin #(
  parameter DEB_CYC = 1000000,
  parameter ACT_LOW = 1
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // raw pin
  input  wire        pin_in,
  // debounced view
  output reg         level_out,
  output reg         press_out,
  output reg         release_out,
  output reg  [31:0] held_out
);

  reg        s1_r;
  reg        s2_r;
  reg [31:0] deb_r;
  wire       raw;
  wire       flip;

  assign raw  = (ACT_LOW != 0) ? ~s2_r : s2_r;
  assign flip = (raw != level_out) && (deb_r >= DEB_CYC - 1);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r        <= (ACT_LOW != 0);
      s2_r        <= (ACT_LOW != 0);
      deb_r       <= 32'h0;
      level_out   <= 1'b0;
      press_out   <= 1'b0;
      release_out <= 1'b0;
      held_out    <= 32'h0;
    end else begin
      s1_r        <= pin_in;
      s2_r        <= s1_r;
      press_out   <= flip & raw;
      release_out <= flip & ~raw;
      if (raw == level_out) begin
        deb_r <= 32'h0;
      end else if (flip) begin
        deb_r <= 32'h0;
      end else begin
        deb_r <= deb_r + 32'h1;
      end
      if (flip) begin
        level_out <= raw;
      end
      // saturate rather than wrap: a stuck key must not look short
      if (flip & raw) begin
        held_out <= 32'h0;
      end else if (level_out && held_out != 32'hFFFFFFFF) begin
        held_out <= held_out + 32'h1;
      end
    end
  end

endmodule // rps_keyin
`default_nettype wire

// ===== rps_bin2bcd.v
// Purpose: convert an 8-bit value to three bcd digits
// Assumes: purely combinational
// Notes:   shift-and-add-three, unrolled by the loop
`timescale 1ns/1ns
`default_nettype none
module rps_bin2bcd (
  // value
  input  wire [7:0]  bin_in,
  // hundreds, tens, units
  output reg  [11:0] bcd_out
);

  integer i;
  reg [19:0] sh;

  always @* begin
    sh = {12'h000, bin_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (sh[11:8] > 4'h4) begin
        sh[11:8] = sh[11:8] + 4'h3;
      end
      if (sh[15:12] > 4'h4) begin
        sh[15:12] = sh[15:12] + 4'h3;
      end
      if (sh[19:16] > 4'h4) begin
        sh[19:16] = sh[19:16] + 4'h3;
      end
      sh = {sh[18:0], 1'b0};
    end
    bcd_out = sh[19:8];
  end

endmodule // rps_bin2bcd
`default_nettype wire

// ===== rps_top.v
// Purpose: front-panel reset key, external reset input and position selector
// Assumes: keys and external reset are asynchronous pins; event flags are local
// Notes:   long counts are parameters so a simulation can shorten them
// Function
// - reset key held over 10 s flashes all indicators together.
// - short local key press or brief external pulse clears triggered events.
// - events whose cause is still present are not cleared.
// - steady external level switches detector off; brief pulse only resets.
// - reset leaves fan running and monitoring active.
// - selector procedure idle about 5 s aborts to flashing point.
// - A b C d I o T U W X are inputs; E F V poll.
// - two keys step positions letter-plus-00 to letter-plus-99.
// - event memory offers slots 01 to 99, 01 newest.
// - airflow position shows percent as 000 to 255.
// - code 000 in module position logs off all modules.
// - firmware position shows version 00 to 99 three times.
// - filter position offers read and set of on, off, time, replacement.
// - key held over 15 s with monitoring starts filter replacement.
`include "rps_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module rps_top #(
  parameter DEB_CYC    = `RPS_DEB_MS * `RPS_CLK_KHZ,
  parameter LAMP_CYC   = `RPS_LAMP_MS * `RPS_CLK_KHZ,
  parameter FREPL_CYC  = `RPS_FREPL_MS * `RPS_CLK_KHZ,
  parameter EXTOFF_CYC = `RPS_EXTOFF_MS * `RPS_CLK_KHZ,
  parameter TOUT_CYC   = `RPS_TOUT_MS * `RPS_CLK_KHZ,
  parameter HALF_CYC   = `RPS_HALF_MS * `RPS_CLK_KHZ
) (
  // clock and reset
  input  wire        SYS_CLK_IN,
  input  wire        RST_N_IN,
  // front-panel pins
  input  wire        RESET_KEY_N_IN,
  input  wire        EXT_RESET_IN,
  input  wire        KEY_UP_N_IN,
  input  wire        KEY_OK_N_IN,
  // event state from the detector core
  input  wire [7:0]  EVENT_ACTIVE_IN,
  input  wire [7:0]  EVENT_PENDING_IN,
  input  wire        FILTER_MON_EN_IN,
  input  wire [7:0]  FLOW_PCT_IN,
  input  wire [6:0]  FW_VERSION_IN,
  // event and power control
  output reg  [7:0]  EVENT_CLEAR_OUT,
  output reg         DETECTOR_OFF_OUT,
  output reg         FAN_RUN_OUT,
  output reg         MONITOR_EN_OUT,
  output reg         LAMP_TEST_OUT,
  output reg         LAMP_FLASH_OUT,
  output reg         FILTER_ISOLATE_OUT,
  // selector actions
  output reg         POS_COMMIT_OUT,
  output reg  [7:0]  POS_LETTER_OUT,
  output reg  [6:0]  POS_NUM_OUT,
  output reg         MODULE_LOGOFF_OUT,
  output reg  [6:0]  EVT_SLOT_OUT,
  output reg         FILT_CMD_OUT,
  output reg         FILT_SET_OUT,
  output reg  [1:0]  FILT_OPT_OUT,
  // segment display
  output reg  [7:0]  DISP_CHAR_OUT,
  output reg  [11:0] DISP_BCD_OUT,
  output reg         DISP_POINT_OUT
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_GROUP = 6'h02;
  localparam [5:0] ST_NUM   = 6'h04;
  localparam [5:0] ST_SUB   = 6'h08;
  localparam [5:0] ST_FOPT  = 6'h10;
  localparam [5:0] ST_SHOW  = 6'h20;

  function [7:0] grp_char;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    grp_char = `RPS_CH_A;
        4'h1:    grp_char = `RPS_CH_B;
        4'h2:    grp_char = `RPS_CH_C;
        4'h3:    grp_char = `RPS_CH_D;
        4'h4:    grp_char = `RPS_CH_E;
        4'h5:    grp_char = `RPS_CH_F;
        4'h6:    grp_char = `RPS_CH_I;
        4'h7:    grp_char = `RPS_CH_O;
        4'h8:    grp_char = `RPS_CH_T;
        4'h9:    grp_char = `RPS_CH_U;
        4'hA:    grp_char = `RPS_CH_V;
        4'hB:    grp_char = `RPS_CH_W;
        4'hC:    grp_char = `RPS_CH_X;
        default: grp_char = `RPS_CH_BLANK;
      endcase
    end
  endfunction

  // only the three polling letters lack a stored setting
  function is_poll;
    input [3:0] idx;
    begin
      is_poll = (idx == `RPS_GRP_E) || (idx == `RPS_GRP_F) || (idx == `RPS_GRP_V);
    end
  endfunction

  wire        rk_lvl;
  wire        rk_press;
  wire        rk_rel;
  wire [31:0] rk_held;
  wire        ex_lvl;
  wire        ex_rel;
  wire [31:0] ex_held;
  wire        up_press;
  wire        ok_press;
  wire [11:0] flow_bcd;
  wire [11:0] fw_bcd;
  wire [11:0] num_bcd;
  reg  [6:0]  num_r;

  rps_keyin #(.DEB_CYC(DEB_CYC), .ACT_LOW(1)) u_rkey (
    .clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN), .pin_in(RESET_KEY_N_IN),
    .level_out(rk_lvl), .press_out(rk_press), .release_out(rk_rel), .held_out(rk_held));
  rps_keyin #(.DEB_CYC(DEB_CYC), .ACT_LOW(0)) u_ext (
    .clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN), .pin_in(EXT_RESET_IN),
    .level_out(ex_lvl), .press_out(), .release_out(ex_rel), .held_out(ex_held));
  rps_keyin #(.DEB_CYC(DEB_CYC), .ACT_LOW(1)) u_up (
    .clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN), .pin_in(KEY_UP_N_IN),
    .level_out(), .press_out(up_press), .release_out(), .held_out());
  rps_keyin #(.DEB_CYC(DEB_CYC), .ACT_LOW(1)) u_ok (
    .clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN), .pin_in(KEY_OK_N_IN),
    .level_out(), .press_out(ok_press), .release_out(), .held_out());

  rps_bin2bcd u_flow (.bin_in(FLOW_PCT_IN), .bcd_out(flow_bcd));
  rps_bin2bcd u_fw (.bin_in({1'b0, FW_VERSION_IN}), .bcd_out(fw_bcd));
  rps_bin2bcd u_num (.bin_in({1'b0, num_r}), .bcd_out(num_bcd));

  // half-second phase for all flashing
  reg [31:0] half_cnt_r;
  reg        blink_r;
  wire       half_tick = (half_cnt_r >= HALF_CYC - 1);
  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      half_cnt_r <= 32'h0;
      blink_r    <= 1'b0;
    end else if (half_tick) begin
      half_cnt_r <= 32'h0;
      blink_r    <= ~blink_r;
    end else begin
      half_cnt_r <= half_cnt_r + 32'h1;
    end
  end

  // reset key, external input and filter replacement
  reg  filt_repl_r;
  reg  clr_req;
  wire repl_start = rk_lvl && (rk_held == FREPL_CYC) && FILTER_MON_EN_IN;
  wire repl_done  = rk_press && filt_repl_r;
  wire sel_repl;
  always @* begin
    // short local press or brief external pulse
    clr_req = (rk_rel && rk_held < LAMP_CYC) || repl_done ||
              (ex_rel && ex_held < EXTOFF_CYC);
  end

  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      filt_repl_r        <= 1'b0;
      EVENT_CLEAR_OUT    <= 8'h00;
      DETECTOR_OFF_OUT   <= 1'b0;
      FAN_RUN_OUT        <= 1'b1;
      MONITOR_EN_OUT     <= 1'b1;
      LAMP_TEST_OUT      <= 1'b0;
      LAMP_FLASH_OUT     <= 1'b0;
      FILTER_ISOLATE_OUT <= 1'b0;
    end else begin
      // start beats completion in the same cycle
      if (repl_start || sel_repl) begin
        filt_repl_r <= 1'b1;
      end else if (repl_done) begin
        filt_repl_r <= 1'b0;
      end
      FILTER_ISOLATE_OUT <= filt_repl_r;
      // pending causes are masked out of the clear
      EVENT_CLEAR_OUT <= {8{clr_req}} & EVENT_ACTIVE_IN & ~EVENT_PENDING_IN;
      // steady level switches off for as long as it stands
      DETECTOR_OFF_OUT <= ex_lvl && (ex_held >= EXTOFF_CYC);
      // a clear never touches fan or monitoring
      FAN_RUN_OUT    <= ~(ex_lvl && (ex_held >= EXTOFF_CYC));
      MONITOR_EN_OUT <= ~(ex_lvl && (ex_held >= EXTOFF_CYC));
      // all indicators flash together, 1 s cycle
      LAMP_TEST_OUT  <= rk_lvl && (rk_held >= LAMP_CYC);
      LAMP_FLASH_OUT <= rk_lvl && (rk_held >= LAMP_CYC) && blink_r;
    end
  end

  // position selector
  reg [5:0]  st_r;
  reg [3:0]  grp_r;
  reg        sub_set_r;
  reg [1:0]  fopt_r;
  reg [2:0]  phase_r;
  reg [31:0] to_cnt_r;
  wire       any_key  = up_press | ok_press;
  wire       time_out = (to_cnt_r >= TOUT_CYC - 1);
  assign sel_repl = (st_r == ST_FOPT) && ok_press && sub_set_r &&
                    (fopt_r == `RPS_FOPT_REPL);

  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r              <= ST_IDLE;
      grp_r             <= 4'h0;
      num_r             <= 7'h00;
      sub_set_r         <= 1'b0;
      fopt_r            <= `RPS_FOPT_ON;
      phase_r           <= 3'h0;
      to_cnt_r          <= 32'h0;
      POS_COMMIT_OUT    <= 1'b0;
      POS_LETTER_OUT    <= 8'h00;
      POS_NUM_OUT       <= 7'h00;
      MODULE_LOGOFF_OUT <= 1'b0;
      EVT_SLOT_OUT      <= 7'h00;
      FILT_CMD_OUT      <= 1'b0;
      FILT_SET_OUT      <= 1'b0;
      FILT_OPT_OUT      <= 2'h0;
    end else begin
      POS_COMMIT_OUT    <= 1'b0;
      MODULE_LOGOFF_OUT <= 1'b0;
      FILT_CMD_OUT      <= 1'b0;
      if (any_key || st_r == ST_IDLE) begin
        to_cnt_r <= 32'h0;
      end else begin
        to_cnt_r <= to_cnt_r + 32'h1;
      end
      if (time_out && !any_key) begin
        st_r <= ST_IDLE;
      end else begin
        case (st_r)
          ST_IDLE: begin
            if (any_key) begin
              st_r  <= ST_GROUP;
              grp_r <= 4'h0;
            end
          end
          ST_GROUP: begin
            if (up_press) begin
              grp_r <= (grp_r == `RPS_GRP_LAST) ? 4'h0 : grp_r + 4'h1;
            end else if (ok_press) begin
              phase_r <= 3'h0;
              if (grp_r == `RPS_GRP_D) begin
                st_r      <= ST_SUB;
                sub_set_r <= 1'b0;
              end else if (grp_r == `RPS_GRP_F || grp_r == `RPS_GRP_V) begin
                st_r <= ST_SHOW;
              end else begin
                st_r  <= ST_NUM;
                // memory starts at the newest slot
                num_r <= (grp_r == `RPS_GRP_E) ? `RPS_SLOT_FIRST : 7'h00;
              end
            end
          end
          ST_NUM: begin
            if (up_press) begin
              if (num_r == `RPS_NUM_MAX) begin
                num_r <= (grp_r == `RPS_GRP_E) ? `RPS_SLOT_FIRST : 7'h00;
              end else begin
                num_r <= num_r + 7'h01;
              end
            end else if (ok_press) begin
              st_r <= ST_IDLE;
              // only input letters commit a setting
              if (!is_poll(grp_r)) begin
                POS_COMMIT_OUT <= 1'b1;
                POS_LETTER_OUT <= grp_char(grp_r);
                POS_NUM_OUT    <= num_r;
              end
              // code 000 logs off every module
              if (grp_r == `RPS_GRP_O && num_r == 7'h00) begin
                MODULE_LOGOFF_OUT <= 1'b1;
              end
            end
            if (grp_r == `RPS_GRP_E) begin
              EVT_SLOT_OUT <= num_r;
            end
          end
          // read or set, then option, on the first channel
          ST_SUB: begin
            if (up_press) begin
              sub_set_r <= ~sub_set_r;
            end else if (ok_press) begin
              st_r   <= ST_FOPT;
              fopt_r <= `RPS_FOPT_ON;
            end
          end
          ST_FOPT: begin
            if (up_press) begin
              fopt_r <= fopt_r + 2'h1;
            end else if (ok_press) begin
              st_r         <= ST_IDLE;
              FILT_CMD_OUT <= 1'b1;
              FILT_SET_OUT <= sub_set_r;
              FILT_OPT_OUT <= fopt_r;
            end
          end
          // firmware shown three times, then back to idle
          ST_SHOW: begin
            if (grp_r == `RPS_GRP_F && half_tick) begin
              if (phase_r == `RPS_FW_PHASES - 3'h1) begin
                st_r <= ST_IDLE;
              end else begin
                phase_r <= phase_r + 3'h1;
              end
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // display drive
  always @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DISP_CHAR_OUT  <= `RPS_CH_BLANK;
      DISP_BCD_OUT   <= 12'h000;
      DISP_POINT_OUT <= 1'b0;
    end else begin
      DISP_POINT_OUT <= (st_r == ST_IDLE) && blink_r;
      case (st_r)
        ST_GROUP: begin
          DISP_CHAR_OUT <= grp_char(grp_r);
          DISP_BCD_OUT  <= 12'h000;
        end
        ST_NUM: begin
          DISP_CHAR_OUT <= grp_char(grp_r);
          DISP_BCD_OUT  <= num_bcd;
        end
        ST_SUB: begin
          DISP_CHAR_OUT <= sub_set_r ? `RPS_CH_S : `RPS_CH_R;
          DISP_BCD_OUT  <= 12'h000;
        end
        ST_FOPT: begin
          DISP_CHAR_OUT <= grp_char(`RPS_GRP_D);
          DISP_BCD_OUT  <= {10'h000, fopt_r};
        end
        ST_SHOW: begin
          if (grp_r == `RPS_GRP_V) begin
            DISP_CHAR_OUT <= `RPS_CH_BLANK;
            DISP_BCD_OUT  <= flow_bcd;
          end else begin
            DISP_CHAR_OUT <= phase_r[0] ? `RPS_CH_BLANK : `RPS_CH_F;
            DISP_BCD_OUT  <= phase_r[0] ? 12'h000 : fw_bcd;
          end
        end
        default: begin
          DISP_CHAR_OUT <= `RPS_CH_BLANK;
          DISP_BCD_OUT  <= 12'h000;
        end
      endcase
    end
  end

endmodule // rps_top
`default_nettype wire

// ===== rps_top_checker.sv
// Purpose: concurrent checks on the ports of rps_top
// Assumes: one clock domain, reset async active low
// Notes:   key pins are raw, so quiet_cnt overstates the idle time a little
`include "rps_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module rps_top_checker #(
  parameter DEB_CYC    = 4,
  parameter EXTOFF_CYC = 100,
  parameter TOUT_CYC   = 150
) (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        EXT_RESET_IN,
  input wire logic        KEY_UP_N_IN,
  input wire logic        KEY_OK_N_IN,
  input wire logic [7:0]  EVENT_ACTIVE_IN,
  input wire logic [7:0]  EVENT_PENDING_IN,
  input wire logic        FILTER_MON_EN_IN,
  input wire logic [7:0]  EVENT_CLEAR_OUT,
  input wire logic        DETECTOR_OFF_OUT,
  input wire logic        FAN_RUN_OUT,
  input wire logic        MONITOR_EN_OUT,
  input wire logic        LAMP_TEST_OUT,
  input wire logic        LAMP_FLASH_OUT,
  input wire logic        FILTER_ISOLATE_OUT,
  input wire logic        POS_COMMIT_OUT,
  input wire logic [7:0]  POS_LETTER_OUT,
  input wire logic [6:0]  POS_NUM_OUT,
  input wire logic        MODULE_LOGOFF_OUT,
  input wire logic [6:0]  EVT_SLOT_OUT,
  input wire logic [7:0]  DISP_CHAR_OUT
);
  logic [15:0] ext_cnt_r;
  logic [15:0] quiet_cnt_r;
  // saturating, so a long run never wraps back below the limits
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_cnt_r   <= 16'h0000;
      quiet_cnt_r <= 16'h0000;
    end else begin
      ext_cnt_r   <= !EXT_RESET_IN ? 16'h0000 : ext_cnt_r + (ext_cnt_r != 16'hFFFF);
      quiet_cnt_r <= (!KEY_UP_N_IN || !KEY_OK_N_IN) ? 16'h0000 :
                     quiet_cnt_r + (quiet_cnt_r != 16'hFFFF);
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_clear;
    EVENT_CLEAR_OUT != 8'h00;
  endsequence
  sequence s_quiet;
    EVENT_CLEAR_OUT == 8'h00;
  endsequence
  sequence s_logoff_code;
    POS_COMMIT_OUT && POS_LETTER_OUT == `RPS_CH_O && POS_NUM_OUT == 7'h00;
  endsequence
  chk_fan_tracks_off: assert property (FAN_RUN_OUT == !DETECTOR_OFF_OUT &&
    MONITOR_EN_OUT == !DETECTOR_OFF_OUT) else $error("fan or monitor wrong");
  chk_off_needs_level: assert property ($rose(DETECTOR_OFF_OUT) |->
    ext_cnt_r >= EXTOFF_CYC) else $error("detector off without steady level");
  chk_clear_not_pending: assert property (
    (EVENT_CLEAR_OUT & $past(EVENT_PENDING_IN)) == 8'h00) else $error("pending event cleared");
  chk_clear_only_active: assert property (
    (EVENT_CLEAR_OUT & ~$past(EVENT_ACTIVE_IN)) == 8'h00) else $error("idle event cleared");
  chk_clear_one_cycle: assert property (s_clear |=> s_quiet)
    else $error("clear pulse too long");
  chk_commit_input: assert property (POS_COMMIT_OUT |-> POS_NUM_OUT <= 7'h63 &&
    POS_LETTER_OUT != `RPS_CH_E && POS_LETTER_OUT != `RPS_CH_F &&
    POS_LETTER_OUT != `RPS_CH_V) else $error("bad commit");
  chk_logoff_code: assert property (MODULE_LOGOFF_OUT |-> s_logoff_code)
    else $error("logoff without code 000");
  chk_slot_range: assert property (EVT_SLOT_OUT <= 7'h63)
    else $error("slot out of range");
  chk_lamp_flash: assert property (LAMP_FLASH_OUT |-> LAMP_TEST_OUT)
    else $error("flash outside lamp test");
  chk_isolate_mon: assert property ($rose(FILTER_ISOLATE_OUT) |->
    $past(FILTER_MON_EN_IN)) else $error("isolate without monitoring");
  chk_idle_timeout: assert property (quiet_cnt_r > TOUT_CYC + DEB_CYC + 8 &&
    !FILTER_ISOLATE_OUT |-> DISP_CHAR_OUT == `RPS_CH_BLANK) else $error("no timeout");
endmodule // rps_top_checker
bind rps_top rps_top_checker #(.DEB_CYC(DEB_CYC), .EXTOFF_CYC(EXTOFF_CYC), .TOUT_CYC(TOUT_CYC))
  u_chk (.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .EXT_RESET_IN(EXT_RESET_IN),
  .KEY_UP_N_IN(KEY_UP_N_IN), .KEY_OK_N_IN(KEY_OK_N_IN), .EVENT_ACTIVE_IN(EVENT_ACTIVE_IN),
  .EVENT_PENDING_IN(EVENT_PENDING_IN), .FILTER_MON_EN_IN(FILTER_MON_EN_IN),
  .EVENT_CLEAR_OUT(EVENT_CLEAR_OUT), .DETECTOR_OFF_OUT(DETECTOR_OFF_OUT),
  .FAN_RUN_OUT(FAN_RUN_OUT), .MONITOR_EN_OUT(MONITOR_EN_OUT), .LAMP_TEST_OUT(LAMP_TEST_OUT),
  .LAMP_FLASH_OUT(LAMP_FLASH_OUT), .FILTER_ISOLATE_OUT(FILTER_ISOLATE_OUT),
  .POS_COMMIT_OUT(POS_COMMIT_OUT), .POS_LETTER_OUT(POS_LETTER_OUT), .POS_NUM_OUT(POS_NUM_OUT),
  .MODULE_LOGOFF_OUT(MODULE_LOGOFF_OUT), .EVT_SLOT_OUT(EVT_SLOT_OUT),
  .DISP_CHAR_OUT(DISP_CHAR_OUT));
`default_nettype wire

// ===== rps_panel_model.sv
// Purpose: fire_alarm_panel model driving the external reset input
// Assumes: bench calls the tasks just after a clock edge
// Notes:   input idles low; pulse length is chosen by the caller
`timescale 1ns/1ns
`default_nettype none
module rps_panel_model (
  input  wire logic clk_in,
  output logic      ext_reset_out
);
  initial ext_reset_out = 1'b0;
  task set_level(input logic lvl);
    @(posedge clk_in);
    ext_reset_out <= lvl;
  endtask
  task brief_pulse(input integer n);
    set_level(1'b1);
    repeat (n) @(posedge clk_in);
    ext_reset_out <= 1'b0;
  endtask
endmodule // rps_panel_model
`default_nettype wire

// ===== reset_and_position_selector_bench.sv
// Purpose: self-checking bench of rps_top
// Assumes: shortened counts, keys driven clean
// Notes:   every pulse output is matched against the expectation queue
`include "rps_defs.vh"
`timescale 1ns/1ns
`default_nettype none
`define RPS_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module reset_and_position_selector_bench;
  localparam integer DEB = 4, LAMP = 200, FREPL = 300, EXTOFF = 100, TOUT = 150, SHORT = 12;
  logic        clk = 1'b0, rst_n = 1'b0, mon_en = 1'b0;
  logic [2:0]  keys_n = 3'b111;
  logic [7:0]  act = 8'h00, pend = 8'h00, flow = 8'h00;
  logic [6:0]  fw = 7'h00;
  logic [15:0] seed = 16'h0BFC;
  logic [7:0]  letters [0:12];
  logic [19:0] exp_q [$];
  integer      err_count = 0, num_checks = 0, cyc = 0, i, j;
  wire         ext_rst;
  wire [7:0]   clr, letter, dchar;
  wire [6:0]   num, slot;
  wire [11:0]  bcd;
  wire [1:0]   fopt;
  wire         doff, fan, mon, lamp, iso, commit, logoff, fcmd, fset;
  always #10 clk = ~clk;
  rps_panel_model panel (.clk_in(clk), .ext_reset_out(ext_rst));
  rps_top #(.DEB_CYC(DEB), .LAMP_CYC(LAMP), .FREPL_CYC(FREPL), .EXTOFF_CYC(EXTOFF),
    .TOUT_CYC(TOUT), .HALF_CYC(10)) DUT (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .RESET_KEY_N_IN(keys_n[0]), .EXT_RESET_IN(ext_rst), .KEY_UP_N_IN(keys_n[1]),
    .KEY_OK_N_IN(keys_n[2]), .EVENT_ACTIVE_IN(act), .EVENT_PENDING_IN(pend),
    .FILTER_MON_EN_IN(mon_en), .FLOW_PCT_IN(flow), .FW_VERSION_IN(fw), .EVENT_CLEAR_OUT(clr),
    .DETECTOR_OFF_OUT(doff), .FAN_RUN_OUT(fan), .MONITOR_EN_OUT(mon), .LAMP_TEST_OUT(lamp),
    .LAMP_FLASH_OUT(), .FILTER_ISOLATE_OUT(iso), .POS_COMMIT_OUT(commit),
    .POS_LETTER_OUT(letter), .POS_NUM_OUT(num), .MODULE_LOGOFF_OUT(logoff),
    .EVT_SLOT_OUT(slot), .FILT_CMD_OUT(fcmd), .FILT_SET_OUT(fset), .FILT_OPT_OUT(fopt),
    .DISP_CHAR_OUT(dchar), .DISP_BCD_OUT(bcd), .DISP_POINT_OUT());
  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task take(input [19:0] got);
    logic [19:0] e;
    e = ~got;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    `RPS_CHK(got, e)
  endtask
  // results are settled at the falling edge
  always @(negedge clk) begin
    if (rst_n) begin
      if (clr !== 8'h00) take({12'h100, clr});
      if (commit === 1'b1) take({4'h2, letter, 1'b0, num});
      if (logoff === 1'b1) take(20'h40000);
      if (fcmd === 1'b1) take({12'h300, 5'h00, fset, fopt});
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task press(input integer k, input integer gap);
    keys_n[k] <= 1'b0;
    repeat (SHORT) @(posedge clk);
    keys_n[k] <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask
  task ups(input integer n);
    repeat (n) press(1, SHORT);
  endtask
  task new_events();
    seed = lfsr(seed);
    act  <= seed[7:0] | 8'h01;
    pend <= seed[15:8] & 8'hFE;
    @(posedge clk);
  endtask
  task idle_wait(input string name);
    repeat (TOUT + 40) @(posedge clk);
    @(negedge clk);
    `RPS_CHK(dchar, `RPS_CH_BLANK)
    $display("test %s done", name);
    @(posedge clk);
  endtask
  initial begin
    letters = '{`RPS_CH_A, `RPS_CH_B, `RPS_CH_C, `RPS_CH_D, `RPS_CH_E, `RPS_CH_F, `RPS_CH_I,
      `RPS_CH_O, `RPS_CH_T, `RPS_CH_U, `RPS_CH_V, `RPS_CH_W, `RPS_CH_X};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      new_events();
      if (i == 3) pend <= act;
      @(posedge clk);
      if (i < 3) exp_q.push_back({12'h100, act & ~pend});
      press(0, SHORT);
    end
    $display("test local reset done");
    for (i = 0; i < 3; i++) begin
      mon_en <= (i == 2);
      keys_n[0] <= 1'b0;
      repeat (LAMP + 30) @(posedge clk);
      @(negedge clk);
      `RPS_CHK(lamp, 1'b1)
      @(posedge clk);
      if (i > 0) begin
        repeat (FREPL - LAMP) @(posedge clk);
        @(negedge clk);
        `RPS_CHK(iso, (i == 2) ? 1'b1 : 1'b0)
        @(posedge clk);
      end
      keys_n[0] <= 1'b1;
      repeat (SHORT) @(posedge clk);
    end
    new_events();
    repeat (2) exp_q.push_back({12'h100, act & ~pend});
    press(0, SHORT);
    @(negedge clk);
    `RPS_CHK(iso, 1'b0)
    $display("test long hold done");
    new_events();
    exp_q.push_back({12'h100, act & ~pend});
    panel.brief_pulse(30);
    repeat (SHORT) @(posedge clk);
    panel.set_level(1'b1);
    repeat (EXTOFF + 30) @(posedge clk);
    @(negedge clk);
    `RPS_CHK(doff, 1'b1)
    `RPS_CHK({fan, mon}, 2'b00)
    panel.set_level(1'b0);
    repeat (SHORT) @(posedge clk);
    @(negedge clk);
    `RPS_CHK(doff, 1'b0)
    `RPS_CHK({fan, mon}, 2'b11)
    $display("test external reset done");
    @(posedge clk);
    for (j = 0; j < 14; j++) begin
      ups(1);
      `RPS_CHK(dchar, letters[j % 13])
    end
    ups(7);
    press(2, SHORT);
    exp_q.push_back({4'h2, `RPS_CH_O, 8'h00});
    exp_q.push_back(20'h40000);
    press(2, SHORT);
    idle_wait("module logoff");
    ups(1);
    for (j = 0; j < 4; j++) press(1, 100);
    `RPS_CHK(dchar, letters[4])
    idle_wait("timeout restart");
    ups(1);
    press(2, SHORT);
    ups(2);
    exp_q.push_back({4'h2, `RPS_CH_A, 8'h02});
    press(2, SHORT);
    idle_wait("commit");
    ups(5);
    press(2, SHORT);
    `RPS_CHK(slot, 7'h01)
    ups(99);
    `RPS_CHK(slot, 7'h01)
    press(2, SHORT);
    idle_wait("event memory");
    seed = lfsr(seed);
    flow <= seed[7:0];
    fw <= seed[14:8] % 100;
    ups(11);
    press(2, SHORT);
    `RPS_CHK(bcd, {4'(flow / 100), 4'((flow / 10) % 10), 4'(flow % 10)})
    idle_wait("airflow");
    ups(6);
    press(2, SHORT);
    do @(negedge clk); while (dchar !== `RPS_CH_F);
    `RPS_CHK(bcd, {4'h0, 4'(fw / 10), 4'(fw % 10)})
    repeat (70) @(posedge clk);
    ups(1);
    `RPS_CHK(dchar, `RPS_CH_A)
    idle_wait("firmware");
    mon_en <= 1'b1;
    ups(4);
    press(2, SHORT);
    ups(1);
    press(2, SHORT);
    ups(2);
    exp_q.push_back({12'h300, 8'h06});
    press(2, SHORT);
    `RPS_CHK(iso, 1'b1)
    new_events();
    repeat (2) exp_q.push_back({12'h100, act & ~pend});
    press(0, SHORT);
    `RPS_CHK(iso, 1'b0)
    `RPS_CHK(exp_q.size(), 0)
    $display("test filter set done");
    conclude();
  end
endmodule // reset_and_position_selector_bench
`default_nettype wire
